/* File: rtl/tcl_p0_dec.sv */
// Decoder of the load/store P0 selector
`timescale 1ns/1ps
module tcl_p0_dec
   import tcl_pkg::*;
(
   // Selector in
   input  wire tcl_p0_t sel,
   // Decoded element classes
   output logic         load_p0,
   output logic         store_p0
);
   // Every two-bit code is legal, so no default
   always_comb begin
      unique case (sel)
         P0_NONE: begin
            load_p0  = 1'b0;
            store_p0 = 1'b0;
         end
         P0_LOAD: begin
            load_p0  = 1'b1;
            store_p0 = 1'b0;
         end
         P0_STORE: begin
            load_p0  = 1'b0;
            store_p0 = 1'b1;
         end
         P0_BOTH: begin
            load_p0  = 1'b1;
            store_p0 = 1'b1;
         end
      endcase
   end
endmodule

/* File: rtl/tcl_pkg.sv */
// Shared constants and types for the trace configuration low-field block
package tcl_pkg;
   // APB register byte offsets
   localparam logic [11:0] CFG_OFFSET  = 12'h000;
   localparam logic [11:0] CAPS_OFFSET = 12'h004;
   localparam logic [11:0] STAT_OFFSET = 12'h008;

   // Configuration register field positions
   localparam int RSV1_BIT = 0;
   localparam int P0_LSB   = 1;
   localparam int P0_MSB   = 2;
   localparam int BB_BIT   = 3;
   localparam int CCI_BIT  = 4;
   localparam int RSV0_BIT = 5;
   localparam int CID_BIT  = 6;
   localparam int DA_BIT   = 16;
   localparam int DV_BIT   = 17;

   // Configuration reset value: only the reserved-one bit is set
   localparam logic [31:0] CFG_RESET = 32'h0000_0001;
   localparam logic [31:0] RES1_MASK = 32'h0000_0001;

   // Capability view register layout
   localparam int CAP_CC_BIT   = 0;
   localparam int CAP_BB_BIT   = 1;
   localparam int CAP_P0_BIT   = 2;
   localparam int CAP_DATA_BIT = 3;
   localparam int CAP_CID_LSB  = 4;
   localparam int CID_W        = 5;

   // Status register layout (effective enables)
   localparam int ST_CID_BIT   = 0;
   localparam int ST_CC_BIT    = 1;
   localparam int ST_BB_BIT    = 2;
   localparam int ST_LOAD_BIT  = 3;
   localparam int ST_STORE_BIT = 4;
   localparam int ST_DA_BIT    = 5;
   localparam int ST_DV_BIT    = 6;
   localparam int ST_CONS_BIT  = 7;

   // Load/store P0 selector encodings
   typedef enum logic [1:0] {
      P0_NONE  = 2'b00,
      P0_LOAD  = 2'b01,
      P0_STORE = 2'b10,
      P0_BOTH  = 2'b11
   } tcl_p0_t;
endpackage

/* File: rtl/tcl_trace_config.sv */
// APB slave holding the low fields of the trace configuration register
`timescale 1ns/1ps
module tcl_trace_config
   import tcl_pkg::*;
#(
   parameter int ADDR_W = 12
)
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Identification fields of the trace unit
   input  wire logic              cycle_count_supported,
   input  wire logic              broadcast_supported,
   input  wire logic              p0_select_supported,
   input  wire logic              data_trace_supported,
   input  wire logic [CID_W-1:0]  context_id_width,
   // Effective trace controls
   output logic                   context_id_trace_on,
   output logic                   cycle_count_on,
   output logic                   branch_broadcast_on,
   output logic                   load_p0,
   output logic                   store_p0,
   output logic                   data_address_trace_on,
   output logic                   data_value_trace_on,
   output logic                   data_stream_events_on,
   output logic                   data_constrained
);

   ////////////////////////////////////////////////////////////////////////
   // Address decode

   // Compare the word address against a register offset
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
      addr_hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
   endfunction

   logic        hit_cfg;     // Configuration register
   logic        hit_caps;    // Capability view
   logic        hit_stat;    // Status view
   logic        hit_any;     // Any mapped word
   logic        setup_rd;    // Setup phase of a read
   logic        acc_wr;      // Completing write
   logic [31:0] impl_mask;   // Implemented configuration bits

   assign hit_cfg  = addr_hit(paddr, CFG_OFFSET);
   assign hit_caps = addr_hit(paddr, CAPS_OFFSET);
   assign hit_stat = addr_hit(paddr, STAT_OFFSET);
   assign hit_any  = hit_cfg | hit_caps | hit_stat;
   assign setup_rd = psel & ~penable & ~pwrite;
   assign acc_wr   = psel & penable & pwrite & pready;

   // Zero wait states: read data is captured during setup
   assign pready  = 1'b1;
   // Unmapped words answer with an error; nothing is stored
   assign pslverr = psel & penable & ~hit_any;

   ////////////////////////////////////////////////////////////////////////
   // Capability masking

   // Which bits are implemented, derived from identification inputs
   tcl_wmask u_wmask (
      .cycle_count_supported (cycle_count_supported),
      .broadcast_supported   (broadcast_supported),
      .p0_select_supported   (p0_select_supported),
      .data_trace_supported  (data_trace_supported),
      .context_id_width      (context_id_width),
      .impl_mask             (impl_mask)
   );

   ////////////////////////////////////////////////////////////////////////
   // Configuration storage

   logic [31:0] cfg_ff;      // Stored configuration
   logic [31:0] nxt_cfg;     // Value a write would store
   logic [31:0] cfg_view;    // Value software reads back

   // Only implemented bits are kept; reserved ones are forced
   assign nxt_cfg  = (pwdata & impl_mask) | RES1_MASK;
   // Mask again on read so a capability that drops reads as zero
   assign cfg_view = (cfg_ff & impl_mask) | RES1_MASK;

   // Software must program this before enabling trace; reset gives
   // a defined all-off value rather than an unknown one
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_ff <= CFG_RESET;
      end else if (acc_wr && hit_cfg) begin
         cfg_ff <= nxt_cfg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Field extraction and decode

   logic    cid_en;      // Context ID field
   logic    cci_en;      // Cycle count field
   logic    bb_en;       // Branch broadcast field
   tcl_p0_t p0_sel;      // Load/store P0 selector
   logic    da_en;       // Data address field
   logic    dv_en;       // Data value field
   logic    dec_load;    // Decoded load class
   logic    dec_store;   // Decoded store class
   logic    cons;        // Selector zero with data enabled

   assign cid_en = cfg_view[CID_BIT];
   assign cci_en = cfg_view[CCI_BIT];
   assign bb_en  = cfg_view[BB_BIT];
   assign p0_sel = tcl_p0_t'(cfg_view[P0_MSB:P0_LSB]);
   assign da_en  = cfg_view[DA_BIT];
   assign dv_en  = cfg_view[DV_BIT];
   // The unit may do either; this design chooses to suppress
   assign cons   = (p0_sel == P0_NONE) & (da_en | dv_en);

   // Selector to element classes
   tcl_p0_dec u_p0_dec (
      .sel      (p0_sel),
      .load_p0  (dec_load),
      .store_p0 (dec_store)
   );

   ////////////////////////////////////////////////////////////////////////
   // Effective control outputs

   logic ctx_ff;     // Context ID tracing on
   logic cc_ff;      // Cycle counting on
   logic bb_ff;      // Branch broadcast on
   logic ld_ff;      // Loads traced as P0
   logic st_ff;      // Stores traced as P0
   logic da_ff;      // Data address tracing on
   logic dv_ff;      // Data value tracing on
   logic ev_ff;      // Data-stream events and triggers on
   logic cons_ff;    // Constrained configuration seen

   // Registered so the trace datapath sees glitch-free enables
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctx_ff  <= 1'b0;
         cc_ff   <= 1'b0;
         bb_ff   <= 1'b0;
         ld_ff   <= 1'b0;
         st_ff   <= 1'b0;
      end else begin
         ctx_ff  <= cid_en;
         cc_ff   <= cci_en;
         bb_ff   <= bb_en;
         ld_ff   <= dec_load;
         st_ff   <= dec_store;
      end
   end

   // Data trace is only produced with a nonzero selector
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         da_ff   <= 1'b0;
         dv_ff   <= 1'b0;
         ev_ff   <= 1'b0;
         cons_ff <= 1'b0;
      end else begin
         da_ff   <= da_en & ~cons;
         dv_ff   <= dv_en & ~cons;
         ev_ff   <= (da_en | dv_en) & ~cons;
         cons_ff <= cons;
      end
   end

   assign context_id_trace_on   = ctx_ff;
   assign cycle_count_on        = cc_ff;
   assign branch_broadcast_on   = bb_ff;
   assign load_p0               = ld_ff;
   assign store_p0              = st_ff;
   assign data_address_trace_on = da_ff;
   assign data_value_trace_on   = dv_ff;
   assign data_stream_events_on = ev_ff;
   assign data_constrained      = cons_ff;

   ////////////////////////////////////////////////////////////////////////
   // Read path

   logic [31:0] caps_view;   // Capability inputs as seen by software
   logic [31:0] stat_view;   // Effective enables
   logic [31:0] nxt_rdata;   // Selected read word
   logic [31:0] rdata_ff;    // Registered read data

   always_comb begin
      caps_view                                 = 32'h0000_0000;
      caps_view[CAP_CC_BIT]                     = cycle_count_supported;
      caps_view[CAP_BB_BIT]                     = broadcast_supported;
      caps_view[CAP_P0_BIT]                     = p0_select_supported;
      caps_view[CAP_DATA_BIT]                   = data_trace_supported;
      caps_view[CAP_CID_LSB+CID_W-1:CAP_CID_LSB] = context_id_width;
   end

   always_comb begin
      stat_view               = 32'h0000_0000;
      stat_view[ST_CID_BIT]   = ctx_ff;
      stat_view[ST_CC_BIT]    = cc_ff;
      stat_view[ST_BB_BIT]    = bb_ff;
      stat_view[ST_LOAD_BIT]  = ld_ff;
      stat_view[ST_STORE_BIT] = st_ff;
      stat_view[ST_DA_BIT]    = da_ff;
      stat_view[ST_DV_BIT]    = dv_ff;
      stat_view[ST_CONS_BIT]  = cons_ff;
   end

   // Unmapped words read as zero
   always_comb begin
      if (hit_cfg) begin
         nxt_rdata = cfg_view;
      end else if (hit_caps) begin
         nxt_rdata = caps_view;
      end else if (hit_stat) begin
         nxt_rdata = stat_view;
      end else begin
         nxt_rdata = 32'h0000_0000;
      end
   end

   // Captured at the end of setup, held through the access phase
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= 32'h0000_0000;
      end else if (setup_rd) begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign prdata = rdata_ff;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   // A completed configuration write
   sequence s_cfg_write;
      psel && penable && pwrite && hit_cfg;
   endsequence

   // Write then settle of the registered enables
   sequence s_settled;
      s_cfg_write ##2 1'b1;
   endsequence

   a_cid_follows: assert property (@(posedge clk) disable iff (!rst_n)
      s_cfg_write |=> ##1 (context_id_trace_on == ($past(pwdata[CID_BIT], 2) && ($past(context_id_width, 2) != 0)
                          && $stable(context_id_width) && $stable(impl_mask)) || !$stable(impl_mask) || $changed(context_id_width)))
      else $error("context id enable does not follow write");

   a_cid_reserved: assert property (@(posedge clk) disable iff (!rst_n)
      (context_id_width == 0) |-> (cfg_view[CID_BIT] == 1'b0))
      else $error("context id bit readable without support");

   a_cc_follows: assert property (@(posedge clk) disable iff (!rst_n)
      (cci_en && $stable(cci_en)) |=> cycle_count_on)
      else $error("cycle count not enabled");

   a_cc_reserved: assert property (@(posedge clk) disable iff (!rst_n)
      !cycle_count_supported [*2] |-> !cycle_count_on)
      else $error("cycle count on without support");

   a_bb_follows: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 branch_broadcast_on == $past(bb_en))
      else $error("broadcast enable mismatch");

   a_bb_reserved: assert property (@(posedge clk) disable iff (!rst_n)
      (!broadcast_supported && (setup_rd && hit_cfg)) |=> !prdata[BB_BIT])
      else $error("broadcast bit read without support");

   a_p0_decode: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 ({store_p0, load_p0} == $past(cfg_view[P0_MSB:P0_LSB])))
      else $error("P0 selector decode wrong");

   a_p0_reserved: assert property (@(posedge clk) disable iff (!rst_n)
      (!p0_select_supported && setup_rd && hit_cfg) |=> (prdata[P0_MSB:P0_LSB] == 2'b00))
      else $error("P0 selector read without support");

   a_cons_quiet: assert property (@(posedge clk) disable iff (!rst_n)
      cons |=> (data_constrained && !data_address_trace_on && !data_value_trace_on))
      else $error("data trace in constrained case");

   a_cons_events: assert property (@(posedge clk) disable iff (!rst_n)
      data_constrained |-> !data_stream_events_on)
      else $error("data events in constrained case");

   // The bus master idles one cycle between transfers, so the read setup lands two edges on
   a_cfg_readback: assert property (@(posedge clk) disable iff (!rst_n)
      (s_cfg_write ##2 (setup_rd && hit_cfg && $stable(impl_mask) && $past($stable(impl_mask))))
      |=> (prdata == $past(nxt_cfg, 3)))
      else $error("configuration readback mismatch");

   a_reserved_bits: assert property (@(posedge clk) disable iff (!rst_n)
      (setup_rd && hit_cfg) |=> (prdata[RSV1_BIT] && !prdata[RSV0_BIT]))
      else $error("reserved bits wrong");

   // An unmapped read must flag an error and return zero data
   a_unmapped_err: assert property (@(posedge clk) disable iff (!rst_n)
      (psel && penable && !pwrite && !hit_any) |-> (pslverr && (prdata == 32'h0000_0000)))
      else $error("unmapped read not refused");

   // Writes to other words leave the configuration untouched
   a_cfg_hold: assert property (@(posedge clk) disable iff (!rst_n)
      (psel && penable && pwrite && !hit_cfg) |=> $stable(cfg_ff))
      else $error("configuration changed by foreign write");

   // A cleared context id field turns tracing off one edge later
   a_cid_off: assert property (@(posedge clk) disable iff (!rst_n)
      !cid_en |=> !context_id_trace_on)
      else $error("context id tracing stuck on");

   // Missing cycle count support hides the field at once
   a_cc_hidden: assert property (@(posedge clk) disable iff (!rst_n)
      !cycle_count_supported |-> !cci_en)
      else $error("cycle count field visible without support");

   // Missing selector support forces the selector to zero
   a_p0_hidden: assert property (@(posedge clk) disable iff (!rst_n)
      !p0_select_supported |-> (p0_sel == P0_NONE))
      else $error("P0 selector visible without support");

   // Data stream events follow the data enables outside the constrained case
   a_ev_follows: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 (data_stream_events_on == $past((da_en | dv_en) & ~cons)))
      else $error("data stream events mismatch");

   // Reserved bits of the readback view are fixed in every cycle
   a_rsv_view: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_view[RSV1_BIT] && !cfg_view[RSV0_BIT])
      else $error("reserved view bits wrong");

endmodule

/* File: rtl/tcl_wmask.sv */
// Writable-bit mask of the configuration register from capability inputs
`timescale 1ns/1ps
module tcl_wmask
   import tcl_pkg::*;
(
   // Capabilities
   input  wire logic             cycle_count_supported,
   input  wire logic             broadcast_supported,
   input  wire logic             p0_select_supported,
   input  wire logic             data_trace_supported,
   input  wire logic [CID_W-1:0] context_id_width,
   // Mask of implemented bits
   output logic      [31:0]      impl_mask
);
   // Unsupported features leave their bits reserved at zero
   always_comb begin
      impl_mask                 = 32'h0000_0000;
      impl_mask[CID_BIT]        = |context_id_width;
      impl_mask[CCI_BIT]        = cycle_count_supported;
      impl_mask[BB_BIT]         = broadcast_supported;
      impl_mask[P0_MSB:P0_LSB]  = {2{p0_select_supported}};
      impl_mask[DA_BIT]         = data_trace_supported;
      impl_mask[DV_BIT]         = data_trace_supported;
   end
endmodule

/* File: tb/tcl_tb.sv */
// Self-checking bench for the trace configuration low-field block
`timescale 1ns/1ps
module tb
   import tcl_pkg::*;
;
   ////////////////////////////////////////////////////////////////////////////
   // Clock, reset, bus and capability drivers
   logic              clk;        // 25 MHz bench clock
   logic              rst_n;      // Active-low reset
   logic              psel;       // APB select
   logic              penable;    // APB access phase
   logic              pwrite;     // APB direction
   logic [11:0]       paddr;      // APB byte address
   logic [31:0]       pwdata;     // APB write data
   logic [31:0]       prdata;     // APB read data
   logic              pready;     // APB ready
   logic              pslverr;    // APB error
   logic [3:0]        caps;       // Data, selector, broadcast, cycle count support
   logic [CID_W-1:0]  cid_w;      // Context id width, zero means absent
   logic [7:0]        ctl;        // Effective controls, status bit order
   logic              ev_on;      // Data stream events allowed
   int                errors;     // Mismatch counter
   int                cmp_count;  // Comparison counter
   int                cyc;        // Timeout cycle counter
   logic [31:0]       seed;       // Xorshift state

   ////////////////////////////////////////////////////////////////////////////
   // Design under test
   tcl_trace_config #(.ADDR_W(12)) dut (
      .clk                   (clk),
      .rst_n                 (rst_n),
      .psel                  (psel),
      .penable               (penable),
      .pwrite                (pwrite),
      .paddr                 (paddr),
      .pwdata                (pwdata),
      .prdata                (prdata),
      .pready                (pready),
      .pslverr               (pslverr),
      .cycle_count_supported (caps[0]),
      .broadcast_supported   (caps[1]),
      .p0_select_supported   (caps[2]),
      .data_trace_supported  (caps[3]),
      .context_id_width      (cid_w),
      .context_id_trace_on   (ctl[0]),
      .cycle_count_on        (ctl[1]),
      .branch_broadcast_on   (ctl[2]),
      .load_p0               (ctl[3]),
      .store_p0              (ctl[4]),
      .data_address_trace_on (ctl[5]),
      .data_value_trace_on   (ctl[6]),
      .data_stream_events_on (ev_on),
      .data_constrained      (ctl[7])
   );

   // Free-running clock, 40 ns period
   always #20 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////
   // Reference model: integers only, no design functions
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Bits that survive a write for the given capabilities
   function automatic logic [31:0] wr_mask(input logic [3:0] c, input logic [CID_W-1:0] w);
      logic [31:0] m;
      m = 32'h0000_0000;
      if (w != '0) m[6] = 1'b1;
      if (c[0]) m[4] = 1'b1;
      if (c[1]) m[3] = 1'b1;
      if (c[2]) m[2:1] = 2'b11;
      if (c[3]) m[17:16] = 2'b11;
      return m;
   endfunction

   // Effective controls; constrained case suppresses data trace
   function automatic logic [7:0] ctl_of(input logic [31:0] e);
      logic cons;
      cons = (e[2:1] == 2'b00) && (e[16] || e[17]);
      return {cons, e[17] & ~cons, e[16] & ~cons, e[2], e[1], e[3], e[4], e[6]};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Compare, bus and closing tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic test_done();
      $display("comparisons=%0d errors=%0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Hang guard, well above the expected run length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         errors++;
         test_done();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      logic [31:0] rd;
      logic [31:0] wd;
      logic [31:0] r;
      logic [31:0] ex;
      logic        er;
      clk = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0000_0000; caps = 4'hF; cid_w = 5'h04;
      errors = 0; cmp_count = 0; cyc = 0; seed = 32'h78C5D504;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      chk({23'h0, ev_on, ctl}, 32'h0000_0000);
      apb(1'b0, CFG_OFFSET, 32'h0, rd, er);
      chk(rd, CFG_RESET);
      ex = CFG_RESET;
      for (int i = 0; i < 64; i++) begin
         // Full support first, then random capability mixes
         r = rnd();
         @(posedge clk);
         caps  <= (i < 8) ? 4'hF : r[3:0];
         cid_w <= (i < 8) ? 5'h1F : r[8:4];
         wd = rnd();
         wd[2:1] = i[1:0];
         @(posedge clk);
         ex = (wd & wr_mask(caps, cid_w)) | RES1_MASK;
         apb(1'b1, CFG_OFFSET, wd, rd, er);
         chk({31'h0, er}, 32'h0);
         apb(1'b0, CFG_OFFSET, 32'h0, rd, er);
         chk(rd, ex);
         chk({24'h0, ctl}, {24'h0, ctl_of(ex)});
         if (ctl_of(ex) & 8'h80) chk({31'h0, ev_on}, 32'h0);
         apb(1'b0, STAT_OFFSET, 32'h0, rd, er);
         chk(rd & 32'hFF, {24'h0, ctl_of(ex)});
         apb(1'b0, CAPS_OFFSET, 32'h0, rd, er);
         chk(rd & 32'h1FF, {23'h0, cid_w, caps});
         if (i % 8 == 7) begin
            // Writes elsewhere must leave the configuration alone
            apb(1'b1, CAPS_OFFSET, rnd(), rd, er);
            chk({31'h0, er}, 32'h0);
            apb(1'b1, 12'h00C, rnd(), rd, er);
            chk({31'h0, er}, 32'h1);
            apb(1'b0, 12'h00C, 32'h0, rd, er);
            chk({er, rd[30:0]}, 32'h8000_0000);
            apb(1'b0, CFG_OFFSET, 32'h0, rd, er);
            chk(rd, ex);
         end
      end
      // Second reset after the loop restores the programmed-before-use state
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      chk({23'h0, ev_on, ctl}, 32'h0000_0000);
      apb(1'b0, CFG_OFFSET, 32'h0, rd, er);
      chk(rd, CFG_RESET);
      test_done();
   end
endmodule
